// ### inc/aso_pkg.sv
// Package for the serial result-output port of the 16-bit converter.
// Assumes one core clock (mclk, 25 MHz) and a host-driven serial clock.
package aso_pkg;

  // Result word and sample buffer
  localparam int RES_W      = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int IDX_W      = 5;

  // Timing: the longest conversion time rounds down to whole cycles
  localparam int MCLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS   = 1500;
  localparam int CONV_CYC       = (CONV_TIME_NS / MCLK_PERIOD_NS < 1) ? 1
                                  : CONV_TIME_NS / MCLK_PERIOD_NS;
  localparam int CONV_CNT_W     = 6;

  // Pin input synchroniser depth
  localparam int SYNC_W = 3;

  // Reset values and the last bit index
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [IDX_W-1:0] IDX_RST    = 5'h00;
  localparam logic [IDX_W-1:0] IDX_LAST   = 5'h10;

  // Three-state serial data output: oe_n low while the pin is driven
  typedef struct packed {
    logic out;
    logic oe_n;
  } aso_sdo_pin_t;

  // Sample word offered by the conversion core
  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] data;
  } aso_sample_t;

endpackage

// ### logic/aso_chain.sv
// Serial result-output port with daisy-chain mode, plus its sample FIFO.
// Assumes pins arrive asynchronous to mclk and that sck is driven by the
// host only between conversions, after busy has fallen.
`timescale 1ns/100ps

module aso_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             level;
  } aso_fifo_st_t;

  aso_fifo_st_t s_q;
  aso_fifo_st_t s_d;
  logic         push;
  logic         pop;

  // Full and empty follow the stored level exactly
  assign in_ready  = (s_q.level != (AW+1)'(DEPTH));
  assign out_valid = (s_q.level != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   s_d.level = s_q.level + 1'b1;
      2'b01:   s_d.level = s_q.level - 1'b1;
      default: s_d.level = s_q.level;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// Contract
// [R1] With chain_select low the port is in normal mode and read_enable_or_serial_in gates sdo.
// [R2] In normal mode sdo floats while read_enable_or_serial_in is high and is driven while low.
// [R3] In normal mode with the enable low, result_msb is on sdo as busy falls.
// [R4] On a shared line the host enables at most one device at a time.
// [R5] On a shared line the host idles every enable high and lowers each in turn to read.
// [R6] Lowering the enable in normal mode puts the held result's MSB on sdo.
// [R7] With chain_select high the port is in chain mode and sdo is always driven.
// [R8] In chain mode read_enable_or_serial_in is the serial input from the upstream part.
// [R9] In chain mode the upstream MSB reaches sdo after 16 sck cycles.
// [R10] In chain mode the first upstream bit is captured on the first rising sck edge.
// [R11] The result loads at conversion end and each sck shifts one place, filling from serial in.
// [R12] A convert_start rising edge starts a conversion and busy stays high throughout it.
// [R13] sdo changes only on rising sck edges; the code also puts the new result's MSB on sdo as busy falls.
// [R14] result_msb stays on sdo until the first rising sck edge.
module aso_chain (
  // Core clock and reset
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  // Serial link clock from the host
  input  wire logic                        sck,
  // Control pins
  input  wire logic                        convert_start,
  input  wire logic                        chain_select,
  input  wire logic                        read_enable_or_serial_in,
  output logic                             busy,
  // Serial data pin
  output aso_pkg::aso_sdo_pin_t            sdo,
  // Samples from the conversion core
  input  wire aso_pkg::aso_sample_t        sample,
  output logic                             sample_ready
);
  import aso_pkg::*;

  // Core-domain state
  typedef struct packed {
    logic [SYNC_W-1:0]     cnv_sync;
    logic                  cnv_lvl;
    logic [SYNC_W-1:0]     chn_sync;
    logic                  chn_lvl;
    logic [SYNC_W-1:0]     rdl_sync;
    logic                  rdl_lvl;
    logic                  busy;
    logic [CONV_CNT_W-1:0] conv_cnt;
    logic [RES_W-1:0]      result;
    logic                  load_tgl;
  } aso_core_st_t;

  // Link-domain state
  typedef struct packed {
    logic             ack_tgl;
    logic [IDX_W-1:0] idx;
    logic [RES_W-1:0] shin;
  } aso_link_st_t;

  aso_core_st_t     c_q;
  aso_core_st_t     c_d;
  aso_link_st_t     l_q;
  aso_link_st_t     l_d;
  logic             conv_done;
  logic             fifo_valid;
  logic [RES_W-1:0] fifo_data;
  logic             fresh;
  logic [IDX_W-1:0] bit_idx;
  logic             sdo_bit;

  // The core offers one word per conversion; the FIFO drains only when a
  // conversion ends, so a fast core is held off through sample_ready.
  aso_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst_n     (resetn),
    .in_valid  (sample.valid),
    .in_ready  (sample_ready),
    .in_data   (sample.data),
    .out_valid (fifo_valid),
    .out_ready (conv_done),
    .out_data  (fifo_data)
  );

  assign conv_done = c_q.busy && (c_q.conv_cnt == CONV_CNT_W'(CONV_CYC - 1));

  always_comb begin
    c_d          = c_q;
    c_d.cnv_sync = {c_q.cnv_sync[SYNC_W-2:0], convert_start};
    c_d.chn_sync = {c_q.chn_sync[SYNC_W-2:0], chain_select};
    c_d.rdl_sync = {c_q.rdl_sync[SYNC_W-2:0], read_enable_or_serial_in};
    // A pin change counts once the second and third stages agree
    if (c_q.cnv_sync[1] == c_q.cnv_sync[2]) begin
      c_d.cnv_lvl = c_q.cnv_sync[2];
    end
    if (c_q.chn_sync[1] == c_q.chn_sync[2]) begin
      c_d.chn_lvl = c_q.chn_sync[2];
    end
    if (c_q.rdl_sync[1] == c_q.rdl_sync[2]) begin
      c_d.rdl_lvl = c_q.rdl_sync[2];
    end
    // Extra edges while busy are ignored: a conversion cannot restart
    if (!c_q.busy && c_d.cnv_lvl && !c_q.cnv_lvl) begin
      c_d.busy     = 1'b1; // [R12]
      c_d.conv_cnt = '0;
    end else if (conv_done) begin
      c_d.busy = 1'b0; // [R12]
      // An empty FIFO leaves the previous result in place
      if (fifo_valid) begin
        c_d.result = fifo_data; // [R11]
      end
      // A load still waiting for its first sck stays pending; toggling again
      // would cancel it and leave the link mid-word on the next read
      c_d.load_tgl = fresh ? c_q.load_tgl : ~c_q.load_tgl; // [R11]
    end else if (c_q.busy) begin
      c_d.conv_cnt = c_q.conv_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      c_q        <= '0;
      c_q.result <= RESULT_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // The result word and its toggle change only as busy falls, and the host
  // clocks sck only after that, so both are static when the link samples them.
  // This trades a formal synchroniser, which would need sck edges that a
  // stopped clock never gives, for that protocol guarantee.
  assign fresh = c_q.load_tgl ^ l_q.ack_tgl;

  always_comb begin
    l_d      = l_q;
    // Every edge shifts; the upstream stream fills from the bottom
    l_d.shin = {l_q.shin[RES_W-2:0], read_enable_or_serial_in}; // [R8] [R10] [R11]
    if (fresh) begin
      l_d.ack_tgl = c_q.load_tgl;
      l_d.idx     = IDX_W'(1); // [R11]
    end else if (l_q.idx != IDX_LAST) begin
      l_d.idx = l_q.idx + 1'b1; // [R11]
    end
  end

  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      l_q     <= '0;
      l_q.idx <= IDX_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // Until the first sck after a load the MSB stands on the pin
  assign bit_idx = fresh ? IDX_RST : l_q.idx; // [R3] [R6] [R14]

  // Bits past the own word come from the serial input, oldest first
  always_comb begin
    if (bit_idx < IDX_LAST) begin
      sdo_bit = c_q.result[(RES_W-1) - int'(bit_idx)]; // [R13]
    end else begin
      sdo_bit = l_q.shin[RES_W-1]; // [R9]
    end
  end

  assign sdo.out = sdo_bit;
  // Chain mode drives always; normal mode follows the enable pin
  assign sdo.oe_n = c_q.chn_lvl ? 1'b0 : c_q.rdl_lvl; // [R1] [R2] [R7]
  assign busy     = c_q.busy; // [R12]

endmodule

// ### tb/aso_chain_asserts.sv
// Checker for the serial result-output port.
// Assumes the ports of aso_chain; the bind stands at the foot.
`timescale 1ns/100ps
module aso_chain_asserts (
  // Core clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Pins
  input wire logic        convert_start,
  input wire logic        chain_select,
  input wire logic        read_enable_or_serial_in,
  input wire logic        busy,
  input wire aso_pkg::aso_sdo_pin_t sdo,
  // Core side
  input wire aso_pkg::aso_sample_t  sample,
  input wire logic        sample_ready
);
  import aso_pkg::*;
  logic [5:0] bcnt_q;
  logic [5:0] lvl_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Level model lags a pop by one edge, so that edge is skipped below
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bcnt_q <= 6'h00;
      lvl_q  <= 6'h00;
    end else begin
      bcnt_q <= busy ? bcnt_q + 6'h01 : 6'h00;
      lvl_q  <= lvl_q + 6'(sample.valid && sample_ready) - 6'($fell(busy) && lvl_q != 6'h00);
    end
  end
  sequence s_conv_run;
    busy[*8];
  endsequence
  a_start_busy: assert property ($rose(convert_start) && !busy |-> ##[3:5] busy)
    else $error("busy late after start");
  a_busy_cause: assert property ($rose(busy) |-> $past(convert_start, 2))
    else $error("busy without start");
  a_busy_min: assert property ($rose(busy) |-> s_conv_run)
    else $error("busy dropped early");
  a_busy_len: assert property ($fell(busy) |-> bcnt_q inside {[6'h24:6'h26]})
    else $error("busy length wrong");
  a_chain_drive: assert property (chain_select[*6] |-> !sdo.oe_n)
    else $error("chain output not driven");
  a_norm_float: assert property ((!chain_select && read_enable_or_serial_in)[*6] |-> sdo.oe_n)
    else $error("output not floating");
  a_norm_drive: assert property ((!chain_select && !read_enable_or_serial_in)[*6] |-> !sdo.oe_n)
    else $error("output not driven");
  a_fifo_level: assert property (!$fell(busy) |-> sample_ready == (lvl_q != 6'h10))
    else $error("buffer ready wrong");
endmodule

bind aso_chain aso_chain_asserts u_aso_chain_asserts (.mclk(mclk), .resetn(resetn),
  .convert_start(convert_start), .chain_select(chain_select), .busy(busy), .sdo(sdo),
  .read_enable_or_serial_in(read_enable_or_serial_in), .sample(sample),
  .sample_ready(sample_ready));

// ### tb/aso_up_model.sv
// Host clock and upstream converter for read-out frames.
// Assumes frames start only after busy has fallen.
`timescale 1ns/100ps
module aso_up_model (
  // Line from the port under test
  input wire logic sdo_in,
  // Link clock and upstream data
  output logic     sck,
  output logic     sdi
);
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
  end
  // Clock stands still outside frames; 48 ns period inside
  task automatic frame(input logic [15:0] up, output logic [31:0] rx);
    int k;
    sdi = up[15];
    #24;
    rx[31] = sdo_in;
    for (k = 1; k < 32; k++) begin
      sck = 1'b1;
      sdi <= (k < 16) ? up[15-k] : ~sdi;
      #24;
      sck = 1'b0;
      rx[31-k] = sdo_in;
      #24;
    end
  endtask
endmodule

// ### tb/tb_aso_chain.sv
// Self-checking bench for the serial result-output port.
// Assumes the upstream model makes sck and the serial input.
`timescale 1ns/100ps
module tb_aso_chain;
  import aso_pkg::*;
  logic         mclk = 1'b0;
  logic         resetn = 1'b0;
  logic         convert_start = 1'b0;
  logic         chain_select = 1'b0;
  logic         rdl_q = 1'b1;
  logic         sck;
  logic         sdi;
  logic         busy;
  logic         sample_ready;
  aso_sdo_pin_t sdo;
  aso_sample_t  sample = '0;
  logic [31:0]  rx;
  int           mismatches = 0;
  int           num_checks = 0;
  int           cyc = 0;
  wire logic    rdl = chain_select ? sdi : rdl_q;
  always #20 mclk = ~mclk;
  aso_chain u_aso_chain (.mclk(mclk), .resetn(resetn), .sck(sck), .convert_start(convert_start),
    .chain_select(chain_select), .read_enable_or_serial_in(rdl), .busy(busy), .sdo(sdo),
    .sample(sample), .sample_ready(sample_ready));
  aso_up_model u_aso_up_model (.sdo_in(sdo.out), .sck(sck), .sdi(sdi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [15:0] w);
    @(posedge mclk) sample <= '{1'b1, w};
    @(posedge mclk) sample <= '0;
  endtask
  task automatic convert;
    int n;
    @(posedge mclk) convert_start <= 1'b1;
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk) convert_start <= 1'b0;
    for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge mclk);
    repeat (2) @(negedge mclk);
  endtask
  task automatic t_normal;
    @(posedge mclk) rdl_q <= 1'b0;
    push(16'hA5C3);
    convert();
    chk(sdo.out, 1'b1);
    u_aso_up_model.frame(16'h0000, rx);
    chk(rx, 32'hA5C3_0000);
  endtask
  task automatic t_shared;
    @(posedge mclk) rdl_q <= 1'b1;
    push(16'h8001);
    convert();
    repeat (6) @(negedge mclk);
    chk(sdo.oe_n, 1'b1);
    @(posedge mclk) rdl_q <= 1'b0;
    repeat (6) @(negedge mclk);
    chk({sdo.oe_n, sdo.out}, 2'b01);
  endtask
  task automatic t_chain;
    @(posedge mclk) chain_select <= 1'b1;
    push(16'h1234);
    convert();
    chk(sdo.oe_n, 1'b0);
    u_aso_up_model.frame(16'hBEEF, rx);
    chk(rx, 32'h1234_BEEF);
  endtask
  // Seventeenth word is refused; an empty buffer keeps the last result
  task automatic t_fifo;
    int i;
    for (i = 0; i < 17; i++) push(16'h0100 + 16'(i));
    @(negedge mclk);
    chk(sample_ready, 1'b0);
    convert();
    chk(sample_ready, 1'b1);
    repeat (16) convert();
    u_aso_up_model.frame(16'h0F0F, rx);
    chk(rx, 32'h010F_0F0F);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_normal();
    t_shared();
    t_chain();
    t_fifo();
    wrap_up();
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
endmodule
